// ==== rtl/serial_port_pkg.sv ====
// Shared constants and types for the serial port programming block.
// Assumes a 16-bit byte address space and 8-bit register data.
package serial_port_pkg;

	// Register addresses, one byte each
	localparam logic [15:0] BASE_ADDR = 16'h3080;
	localparam logic [15:0] ADDR_BAUD_HIGH = 16'h3080;
	localparam logic [15:0] ADDR_BAUD_LOW = 16'h3081;
	localparam logic [15:0] ADDR_CONTROL_ONE = 16'h3082;
	localparam logic [15:0] ADDR_CONTROL_TWO = 16'h3083;
	localparam logic [15:0] ADDR_STATUS_ONE = 16'h3084;
	localparam logic [15:0] ADDR_STATUS_TWO = 16'h3085;
	localparam logic [15:0] ADDR_CONTROL_THREE = 16'h3086;
	localparam logic [15:0] ADDR_DATA_PORT = 16'h3087;
	localparam logic [15:0] ADDR_IRQ_STATUS = 16'h3088;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'h3089;

	// Values after reset
	localparam logic [7:0] RST_BAUD_HIGH = 8'h00;
	localparam logic [7:0] RST_BAUD_LOW = 8'h04;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_STATUS_ONE = 8'hc0;

	// Baud high fields
	localparam int BH_BREAK_IRQ_EN = 7;
	localparam int BH_EDGE_IRQ_EN = 6;
	localparam int BH_STOP_COUNT = 5;
	localparam int DIV_HIGH_BITS = 5;

	// Control one fields
	localparam int C1_LOOPBACK = 7;
	localparam int C1_FREEZE_WAIT = 6;
	localparam int C1_RX_SOURCE = 5;
	localparam int C1_NINE_BIT = 4;
	localparam int C1_WAKE_ADDR = 3;
	localparam int C1_IDLE_AFTER_STOP = 2;
	localparam int C1_PARITY_EN = 1;
	localparam int C1_PARITY_ODD = 0;

	// Control two, control three and status two fields
	localparam int C2_TX_ON = 3;
	localparam int C2_RX_ON = 2;
	localparam int C3_TX_PIN_OUT = 5;
	localparam int S2_BREAK_FLAG = 7;
	localparam int S2_EDGE_FLAG = 6;

	// Interrupt status bits
	localparam int IRQ_BREAK = 0;
	localparam int IRQ_EDGE = 1;
	localparam int IRQ_DIV_COMMIT = 2;
	localparam int IRQ_BITS = 3;

	// Baud generator
	localparam int DIV_WIDTH = 13;
	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'(OVERSAMPLE - 1);
	// Start, eight data bits and one stop bit; the ninth bit and a second stop add to it
	localparam logic [3:0] FRAME_BASE_BITS = 4'ha;

	// Line configuration handed to the shift logic
	typedef struct packed {
		logic two_stop;
		logic nine_bit;
		logic parity_en;
		logic parity_odd;
		logic wake_addr;
		logic idle_after_stop;
		logic freeze_in_wait;
		logic [3:0] frame_bits;
	} line_cfg_s;

	// Register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;

endpackage : serial_port_pkg

// ==== rtl/baud_tick_gen.sv ====
// Baud generator: divides the bus clock by the divisor for a 16x sample tick
// and by sixteen again for a bit tick. Assumes a single clock domain.
`timescale 1ns/1ns
module baud_tick_gen #(
	parameter int WIDTH = serial_port_pkg::DIV_WIDTH
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [WIDTH-1:0] divisor,
	output logic sample_tick,
	output logic bit_tick,
	output logic running
);

	logic [WIDTH-1:0] count; // Bus clocks within one sample period
	logic [WIDTH-1:0] active_div; // Divisor in use for the current period
	logic [3:0] phase; // Sample ticks within one bit
	logic reload; // Last clock of a sample period
	logic [WIDTH-1:0] period; // Length of the sample period now being counted

	// A zero divisor holds the counters still so nothing toggles
	assign running = enable && (divisor != '0);
	// Restarting from a zero divisor leaves active_div at zero for one period, because
	// it was loaded on the same edge as the low write; the live divisor sets that period
	assign period = (active_div == '0) ? divisor : active_div;
	assign reload = running && (count == period - WIDTH'(1));
	assign sample_tick = reload;
	assign bit_tick = reload && (phase == serial_port_pkg::OVERSAMPLE_LAST);

	// Period counter; new divisor taken only at reload so no period is cut short
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			active_div <= '0;
		end else if (!running) begin
			count <= '0;
			active_div <= divisor;
		end else if (reload) begin
			count <= '0;
			active_div <= divisor;
		end else begin
			count <= count + WIDTH'(1);
		end
	end

	// Oversample phase counter
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= '0;
		end else if (!running) begin
			phase <= '0;
		end else if (reload) begin
			phase <= phase + 4'h1;
		end
	end

endmodule : baud_tick_gen

// ==== rtl/serial_port_baud_and_regs.sv ====
// Register bank, divisor buffering, baud generator control and line routing
// of an asynchronous serial port. Assumes the shift logic sits outside on the
// same clock and that rxd and txd pins arrive asynchronously.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
module serial_port_baud_and_regs (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic [7:0] status_one_in,
	input wire logic break_event,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_data_load,
	output logic [7:0] tx_data,
	output logic tx_data_load,
	input wire logic tx_serial,
	input wire logic rxd_pin,
	input wire logic txd_pin_in,
	output logic txd_pin_out,
	output logic txd_pin_oe,
	output logic rx_serial,
	output logic [7:0] control_two_out,
	output logic [7:0] control_three_out,
	output serial_port_pkg::line_cfg_s line_cfg,
	output logic sample_tick,
	output logic bit_tick,
	output logic baud_running,
	output logic line_irq,
	output logic irq
);

	serial_port_pkg::bus_req_s req; // Bundled bus request

	logic [7:0] baud_high; // Working high register
	logic [7:0] baud_high_buf; // High half waiting for the low write
	logic [7:0] baud_low; // Working low register
	logic [7:0] control_one; // Line options
	logic [7:0] control_two; // Enables for the shift logic
	logic [7:0] status_one; // Copy of the shift logic status
	logic [7:0] status_two; // Flags and status two options
	logic [7:0] control_three; // Further options
	logic [7:0] data_port; // Last received byte
	logic [serial_port_pkg::IRQ_BITS-1:0] irq_status; // Sticky events
	logic [serial_port_pkg::IRQ_BITS-1:0] irq_mask; // Event mask
	logic gen_armed; // Set once the receiver or transmitter is enabled
	logic [serial_port_pkg::DIV_WIDTH-1:0] divisor; // Working divisor
	logic rxd_meta; // First synchroniser stage, rxd pin
	logic rxd_sync; // Second synchroniser stage, rxd pin
	logic txd_meta; // First synchroniser stage, txd pin
	logic txd_sync; // Second synchroniser stage, txd pin
	logic rx_prev; // Receive input one clock ago
	logic edge_event; // Falling edge on the receive input
	logic div_commit; // Low register written this cycle
	logic wr_hit_high; // Decoded write strobes
	logic wr_hit_low;
	logic wr_hit_c1;
	logic wr_hit_c2;
	logic wr_hit_s2;
	logic wr_hit_c3;
	logic wr_hit_data;
	logic wr_hit_mask;
	logic rd_hit_irq; // Read of the interrupt status clears it

	// Address match, shared by the write and read paths
	function automatic logic hit(input logic [15:0] addr, input logic [15:0] reg_addr);
		hit = (addr == reg_addr);
	endfunction : hit

	assign req.addr = bus_addr;
	assign req.wdata = bus_wdata;
	assign req.wr = bus_wr;
	assign req.rd = bus_rd;

	// Write decode; status one is read-only so it has no strobe
	assign wr_hit_high = req.wr && hit(req.addr, serial_port_pkg::ADDR_BAUD_HIGH);
	assign wr_hit_low = req.wr && hit(req.addr, serial_port_pkg::ADDR_BAUD_LOW);
	assign wr_hit_c1 = req.wr && hit(req.addr, serial_port_pkg::ADDR_CONTROL_ONE);
	assign wr_hit_c2 = req.wr && hit(req.addr, serial_port_pkg::ADDR_CONTROL_TWO);
	assign wr_hit_s2 = req.wr && hit(req.addr, serial_port_pkg::ADDR_STATUS_TWO);
	assign wr_hit_c3 = req.wr && hit(req.addr, serial_port_pkg::ADDR_CONTROL_THREE);
	assign wr_hit_data = req.wr && hit(req.addr, serial_port_pkg::ADDR_DATA_PORT);
	assign wr_hit_mask = req.wr && hit(req.addr, serial_port_pkg::ADDR_IRQ_MASK);
	assign rd_hit_irq = req.rd && hit(req.addr, serial_port_pkg::ADDR_IRQ_STATUS);
	assign div_commit = wr_hit_low;

	// High register: flag bits act at once, divisor bits wait for the low write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_high <= serial_port_pkg::RST_BAUD_HIGH;
			baud_high_buf <= serial_port_pkg::RST_BAUD_HIGH;
		end else begin
			if (wr_hit_high) begin
				baud_high_buf <= req.wdata;
				baud_high[7:5] <= req.wdata[7:5];
			end
			if (wr_hit_low) begin
				baud_high[4:0] <= baud_high_buf[4:0];
			end
		end
	end

	// Low register; its write commits the whole divisor
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			baud_low <= serial_port_pkg::RST_BAUD_LOW;
		end else if (wr_hit_low) begin
			baud_low <= req.wdata;
		end
	end

	// Divisor assembly
	assign divisor = {baud_high[serial_port_pkg::DIV_HIGH_BITS-1:0], baud_low};

	// Control registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			control_one <= serial_port_pkg::RST_ZERO;
			control_two <= serial_port_pkg::RST_ZERO;
			control_three <= serial_port_pkg::RST_ZERO;
		end else begin
			if (wr_hit_c1) begin
				control_one <= req.wdata;
			end
			if (wr_hit_c2) begin
				control_two <= req.wdata;
			end
			if (wr_hit_c3) begin
				control_three <= req.wdata;
			end
		end
	end

	// Arming: a nonzero reset divisor must not start the generator on its own
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			gen_armed <= 1'b0;
		end else if (wr_hit_c2 && (req.wdata[serial_port_pkg::C2_RX_ON] ||
				req.wdata[serial_port_pkg::C2_TX_ON])) begin
			gen_armed <= 1'b1;
		end
	end

	// Status one mirrors the shift logic; software cannot write it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_one <= serial_port_pkg::RST_STATUS_ONE;
		end else begin
			status_one <= status_one_in;
		end
	end

	// Status two: flags clear on a written one, but a same-cycle event wins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_two <= serial_port_pkg::RST_ZERO;
		end else begin
			if (wr_hit_s2) begin
				status_two[5:0] <= req.wdata[5:0];
			end
			if (break_event) begin
				status_two[serial_port_pkg::S2_BREAK_FLAG] <= 1'b1;
			end else if (wr_hit_s2 && req.wdata[serial_port_pkg::S2_BREAK_FLAG]) begin
				status_two[serial_port_pkg::S2_BREAK_FLAG] <= 1'b0;
			end
			if (edge_event) begin
				status_two[serial_port_pkg::S2_EDGE_FLAG] <= 1'b1;
			end else if (wr_hit_s2 && req.wdata[serial_port_pkg::S2_EDGE_FLAG]) begin
				status_two[serial_port_pkg::S2_EDGE_FLAG] <= 1'b0;
			end
		end
	end

	// Data port: written bytes go to the transmitter, received bytes land here
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_port <= serial_port_pkg::RST_ZERO;
			tx_data <= serial_port_pkg::RST_ZERO;
			tx_data_load <= 1'b0;
		end else begin
			tx_data_load <= wr_hit_data;
			if (wr_hit_data) begin
				tx_data <= req.wdata;
			end
			if (rx_data_load) begin
				data_port <= rx_data_in;
			end
		end
	end

	// Pin synchronisers; only the second stage is read by logic
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
			txd_meta <= 1'b1;
			txd_sync <= 1'b1;
		end else begin
			rxd_meta <= rxd_pin;
			rxd_sync <= rxd_meta;
			txd_meta <= txd_pin_in;
			txd_sync <= txd_meta;
		end
	end

	// Receive input routing: pin, internal loop or single wire
	always_comb begin
		if (!control_one[serial_port_pkg::C1_LOOPBACK]) begin
			rx_serial = rxd_sync;
		end else if (control_one[serial_port_pkg::C1_RX_SOURCE]) begin
			rx_serial = txd_sync;
		end else begin
			rx_serial = tx_serial;
		end
	end

	// Transmit pin; in single-wire mode direction follows control three
	assign txd_pin_out = tx_serial;
	assign txd_pin_oe = !(control_one[serial_port_pkg::C1_LOOPBACK] &&
		control_one[serial_port_pkg::C1_RX_SOURCE]) ||
		control_three[serial_port_pkg::C3_TX_PIN_OUT];

	// Active edge detect on whatever feeds the receiver
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_prev <= 1'b1;
		end else begin
			rx_prev <= rx_serial;
		end
	end
	assign edge_event = rx_prev && !rx_serial;

	// Line options for the shift logic
	assign line_cfg.two_stop = baud_high[serial_port_pkg::BH_STOP_COUNT];
	assign line_cfg.nine_bit = control_one[serial_port_pkg::C1_NINE_BIT];
	assign line_cfg.parity_en = control_one[serial_port_pkg::C1_PARITY_EN];
	assign line_cfg.parity_odd = control_one[serial_port_pkg::C1_PARITY_ODD];
	assign line_cfg.wake_addr = control_one[serial_port_pkg::C1_WAKE_ADDR];
	assign line_cfg.idle_after_stop = control_one[serial_port_pkg::C1_IDLE_AFTER_STOP];
	assign line_cfg.freeze_in_wait = control_one[serial_port_pkg::C1_FREEZE_WAIT];
	// Start, eight data bits, optional ninth, one or two stops; parity is inside the data
	assign line_cfg.frame_bits = serial_port_pkg::FRAME_BASE_BITS +
		{3'h0, control_one[serial_port_pkg::C1_NINE_BIT]} +
		{3'h0, baud_high[serial_port_pkg::BH_STOP_COUNT]};

	assign control_two_out = control_two;
	assign control_three_out = control_three;

	// Baud generator
	baud_tick_gen #(
		.WIDTH(serial_port_pkg::DIV_WIDTH)
	) u_baud (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.enable(gen_armed),
		.divisor(divisor),
		.sample_tick(sample_tick),
		.bit_tick(bit_tick),
		.running(baud_running)
	);

	// Line interrupt request: flag gated by its enable, polled otherwise
	assign line_irq = (status_two[serial_port_pkg::S2_BREAK_FLAG] &&
		baud_high[serial_port_pkg::BH_BREAK_IRQ_EN]) ||
		(status_two[serial_port_pkg::S2_EDGE_FLAG] &&
		baud_high[serial_port_pkg::BH_EDGE_IRQ_EN]);

	// Sticky event status, cleared by read; a new event in that cycle survives
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= '0;
		end else begin
			irq_status <= (rd_hit_irq ? '0 : irq_status) |
				{div_commit, edge_event, break_event};
		end
	end

	// Interrupt mask
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= '0;
		end else if (wr_hit_mask) begin
			irq_mask <= req.wdata[serial_port_pkg::IRQ_BITS-1:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	// Read data one clock after the strobe; unmapped addresses read zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= '0;
		end else if (!req.rd) begin
			bus_rdata <= '0;
		end else if (hit(req.addr, serial_port_pkg::ADDR_BAUD_HIGH)) begin
			bus_rdata <= {baud_high[7:5], baud_high_buf[4:0]};
		end else if (hit(req.addr, serial_port_pkg::ADDR_BAUD_LOW)) begin
			bus_rdata <= baud_low;
		end else if (hit(req.addr, serial_port_pkg::ADDR_CONTROL_ONE)) begin
			bus_rdata <= control_one;
		end else if (hit(req.addr, serial_port_pkg::ADDR_CONTROL_TWO)) begin
			bus_rdata <= control_two;
		end else if (hit(req.addr, serial_port_pkg::ADDR_STATUS_ONE)) begin
			bus_rdata <= status_one;
		end else if (hit(req.addr, serial_port_pkg::ADDR_STATUS_TWO)) begin
			bus_rdata <= status_two;
		end else if (hit(req.addr, serial_port_pkg::ADDR_CONTROL_THREE)) begin
			bus_rdata <= control_three;
		end else if (hit(req.addr, serial_port_pkg::ADDR_DATA_PORT)) begin
			bus_rdata <= data_port;
		end else if (hit(req.addr, serial_port_pkg::ADDR_IRQ_STATUS)) begin
			bus_rdata <= {5'h00, irq_status};
		end else if (hit(req.addr, serial_port_pkg::ADDR_IRQ_MASK)) begin
			bus_rdata <= {5'h00, irq_mask};
		end else begin
			bus_rdata <= '0;
		end
	end

endmodule : serial_port_baud_and_regs

// ==== testbench/serial_line_model.sv ====
// Far-end serial transceiver on the receive and transmit wires.
// Assumes the bench calls send_low on the block's own clock.
`timescale 1ns/1ns
module serial_line_model (
	input wire logic ref_clk,
	input wire logic txd_pin_out,
	input wire logic txd_pin_oe,
	output logic rxd_pin,
	output logic txd_wire
);
	// Pulled-up wire: reads high once the block lets go of it
	assign txd_wire = txd_pin_oe ? txd_pin_out : 1'b1;
	// The line rests at mark between characters
	initial rxd_pin = 1'b1;
	// Space for n clocks, as a start bit or a break would show
	task send_low(input int n);
		@(posedge ref_clk);
		rxd_pin <= 1'b0;
		repeat (n) @(posedge ref_clk);
		rxd_pin <= 1'b1;
	endtask : send_low
endmodule : serial_line_model

// ==== testbench/serial_port_baud_and_regs_chk.sv ====
// Port checker for the serial port register and baud block.
// Assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/1ns
module serial_port_baud_and_regs_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic [7:0] rx_data_in,
	input wire logic rx_data_load,
	input wire logic [7:0] tx_data,
	input wire logic tx_data_load,
	input wire logic tx_serial,
	input wire logic txd_pin_out,
	input wire serial_port_pkg::line_cfg_s line_cfg,
	input wire logic sample_tick,
	input wire logic bit_tick,
	input wire logic baud_running,
	input wire logic line_irq,
	input wire logic irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Set once software turns the receiver or transmitter on
	logic armed;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else if (bus_wr && bus_addr == serial_port_pkg::ADDR_CONTROL_TWO
			&& (bus_wdata[serial_port_pkg::C2_TX_ON] || bus_wdata[serial_port_pkg::C2_RX_ON])) begin
			armed <= 1'b1;
		end
	end
	// Divisor as software last committed it; the high half waits for the low write
	logic [4:0] high_seen;
	logic [12:0] div_seen;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_seen <= 5'(serial_port_pkg::RST_BAUD_HIGH);
			div_seen <= {5'(serial_port_pkg::RST_BAUD_HIGH), serial_port_pkg::RST_BAUD_LOW};
		end else if (bus_wr && bus_addr == serial_port_pkg::ADDR_BAUD_HIGH) begin
			high_seen <= bus_wdata[4:0];
		end else if (bus_wr && bus_addr == serial_port_pkg::ADDR_BAUD_LOW) begin
			div_seen <= {high_seen, bus_wdata};
		end
	end
	property p_rdata_idle;
		!bus_rd |=> bus_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	property p_unmapped;
		bus_rd && (bus_addr > serial_port_pkg::ADDR_IRQ_MASK
			|| bus_addr < serial_port_pkg::BASE_ADDR) |=> bus_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rx_read;
		rx_data_load ##1 (bus_rd && bus_addr == serial_port_pkg::ADDR_DATA_PORT
			&& !rx_data_load) |=> bus_rdata == $past(rx_data_in, 2);
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("received byte lost");
	property p_tx_load;
		bus_wr && bus_addr == serial_port_pkg::ADDR_DATA_PORT
			|=> tx_data_load && tx_data == $past(bus_wdata);
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("transmit byte not handed on");
	property p_idle_unarmed;
		!armed |-> !baud_running && !sample_tick;
	endproperty
	a_idle_unarmed: assert property (p_idle_unarmed) else $error("generator ran early");
	property p_tick_run;
		(sample_tick |-> baud_running) and (baud_running |-> div_seen != 13'h0000);
	endproperty
	a_tick_run: assert property (p_tick_run) else $error("tick while stopped");
	property p_bit_tick;
		bit_tick |-> sample_tick ##1 !bit_tick [*8];
	endproperty
	a_bit_tick: assert property (p_bit_tick) else $error("bit tick spacing");
	property p_frame;
		line_cfg.frame_bits == serial_port_pkg::FRAME_BASE_BITS
			+ 4'(line_cfg.nine_bit) + 4'(line_cfg.two_stop);
	endproperty
	a_frame: assert property (p_frame) else $error("frame length wrong");
	property p_txd;
		txd_pin_out == tx_serial;
	endproperty
	a_txd: assert property (p_txd) else $error("transmit pin not following");
	c_run: cover property ($rose(baud_running));
	c_irq: cover property ($rose(irq));
	c_line: cover property ($rose(line_irq));
endmodule : serial_port_baud_and_regs_chk
bind serial_port_baud_and_regs serial_port_baud_and_regs_chk u_chk (.ref_clk, .rst_n,
	.bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .rx_data_in, .rx_data_load,
	.tx_data, .tx_data_load, .tx_serial, .txd_pin_out, .line_cfg, .sample_tick,
	.bit_tick, .baud_running, .line_irq, .irq);

// ==== testbench/test_serial_port_baud_and_regs.sv ====
// Self-checking bench for the serial port register and baud block.
// Assumes the line model on the pins and one 250 MHz clock.
`timescale 1ns/1ns
module test_serial_port_baud_and_regs;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] status_one_in = 8'hc0;
	logic break_event = 1'b0;
	logic [7:0] rx_data_in = 8'h00;
	logic rx_data_load = 1'b0;
	logic tx_serial = 1'b1;
	logic [7:0] bus_rdata, tx_data, control_two_out, control_three_out, rd_val;
	logic tx_data_load, rxd_pin, txd_wire, txd_pin_out, txd_pin_oe, rx_serial;
	logic sample_tick, bit_tick, baud_running, line_irq, irq;
	serial_port_pkg::line_cfg_s line_cfg;
	int n_fail = 0;
	int compares = 0;
	int gap_n;
	// Reset value of each of the first eight offsets
	logic [7:0] rst_tab [8] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h00};
	// Address, write data, read-back
	logic [31:0] rows [9] = '{32'h3082a5a5, 32'h30863c3c, 32'h30853f3f, 32'h3084115a,
		32'h308aff00, 32'h30890707, 32'h30830000, 32'h3080e3e3, 32'h30875500};
	serial_port_baud_and_regs dut (.ref_clk, .rst_n, .bus_addr, .bus_wdata, .bus_wr,
		.bus_rd, .bus_rdata, .status_one_in, .break_event, .rx_data_in, .rx_data_load,
		.tx_data, .tx_data_load, .tx_serial, .rxd_pin, .txd_pin_in(txd_wire), .txd_pin_out,
		.txd_pin_oe, .rx_serial, .control_two_out, .control_three_out, .line_cfg,
		.sample_tick, .bit_tick, .baud_running, .line_irq, .irq);
	serial_line_model line (.ref_clk, .txd_pin_out, .txd_pin_oe, .rxd_pin, .txd_wire);
	always #2 ref_clk = ~ref_clk;
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	// One-cycle write; an idle cycle keeps strobes from being driven twice
	task bw(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
	endtask : bw
	// Read data stands only in the cycle after the strobe
	task br(input logic [15:0] a);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1 rd_val = bus_rdata;
	endtask : br
	task pulse_break;
		@(posedge ref_clk);
		break_event <= 1'b1;
		@(posedge ref_clk);
		break_event <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : pulse_break
	// Clocks between two ticks, sampled at the falling edge where they are settled
	task gap(input logic bits, input int n);
		int k;
		k = 0;
		repeat (2) begin
			@(negedge ref_clk);
			while (!(bits ? bit_tick : sample_tick) && k < 5000) begin
				@(negedge ref_clk);
				k++;
			end
		end
		gap_n = 0;
		do begin
			@(negedge ref_clk);
			gap_n++;
		end while (!(bits ? bit_tick : sample_tick) && gap_n < 5000);
		chk(16'(gap_n), 16'(n));
	endtask : gap
	task test_done;
		if (n_fail == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	// Watchdog well beyond the expected run
	initial begin
		#200000;
		n_fail++;
		test_done;
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			br(serial_port_pkg::BASE_ADDR + 16'(i));
			chk(rd_val, rst_tab[i]);
		end
		status_one_in <= 8'h5a;
		foreach (rows[i]) begin
			bw(rows[i][31:16], rows[i][15:8]);
			br(rows[i][31:16]);
			chk(rd_val, rows[i][7:0]);
		end
		chk(line_cfg, {1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'hb});
		chk(baud_running, 1'b0);
		chk(control_three_out, 8'h3c);
		// Routing: single wire hears the pin, driven per control three; then internal loop; then the rxd pin
		chk(txd_pin_oe, 1'b1);
		@(posedge ref_clk);
		tx_serial <= 1'b0;
		repeat (4) @(posedge ref_clk);
		#1 chk(rx_serial, 1'b0);
		bw(serial_port_pkg::ADDR_CONTROL_ONE, 8'h80);
		#1 chk(rx_serial, 1'b0);
		@(posedge ref_clk);
		tx_serial <= 1'b1;
		@(posedge ref_clk);
		#1 chk(rx_serial, 1'b1);
		bw(serial_port_pkg::ADDR_CONTROL_ONE, 8'h00);
		fork
			line.send_low(8);
			begin
				repeat (5) @(posedge ref_clk);
				#1 chk(rx_serial, 1'b0);
			end
		join
		// Received byte reads back at once
		@(posedge ref_clk);
		rx_data_in <= 8'h9c;
		rx_data_load <= 1'b1;
		@(posedge ref_clk);
		rx_data_load <= 1'b0;
		bus_addr <= serial_port_pkg::ADDR_DATA_PORT;
		bus_rd <= 1'b1;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1 chk(bus_rdata, 8'h9c);
		// Arm with reset divisor, then rates
		bw(serial_port_pkg::ADDR_CONTROL_TWO, 8'h04);
		#1 chk(control_two_out, 8'h04);
		gap(1'b0, 4);
		gap(1'b1, 64);
		bw(serial_port_pkg::ADDR_BAUD_HIGH, 8'h01);
		gap(1'b0, 4);
		bw(serial_port_pkg::ADDR_BAUD_LOW, 8'h03);
		gap(1'b0, 259);
		bw(serial_port_pkg::ADDR_BAUD_HIGH, 8'h00);
		bw(serial_port_pkg::ADDR_BAUD_LOW, 8'h00);
		repeat (3) @(posedge ref_clk);
		#1 chk(baud_running, 1'b0);
		bw(serial_port_pkg::ADDR_BAUD_LOW, 8'h04);
		gap(1'b0, 4);
		// Interrupts: clear, raise, poll, mask
		bw(serial_port_pkg::ADDR_STATUS_TWO, 8'hc0);
		br(serial_port_pkg::ADDR_IRQ_STATUS);
		chk(rd_val, 8'h06);
		chk({irq, line_irq}, 2'b00);
		bw(serial_port_pkg::ADDR_BAUD_HIGH, 8'h80);
		pulse_break;
		chk({irq, line_irq}, 2'b11);
		bw(serial_port_pkg::ADDR_BAUD_HIGH, 8'h00);
		#1 chk(line_irq, 1'b0);
		br(serial_port_pkg::ADDR_STATUS_TWO);
		chk(rd_val & 8'h80, 8'h80);
		br(serial_port_pkg::ADDR_IRQ_STATUS);
		chk(rd_val, 8'h01);
		chk(irq, 1'b0);
		bw(serial_port_pkg::ADDR_IRQ_MASK, 8'h00);
		pulse_break;
		chk(irq, 1'b0);
		br(serial_port_pkg::ADDR_IRQ_STATUS);
		chk(rd_val, 8'h01);
		bw(serial_port_pkg::ADDR_STATUS_TWO, 8'hc0);
		bw(serial_port_pkg::ADDR_BAUD_HIGH, 8'h40);
		#1 chk(line_irq, 1'b0);
		line.send_low(4);
		repeat (3) @(posedge ref_clk);
		#1 chk(line_irq, 1'b1);
		// Reset in mid-run puts the bank and the generator back to rest
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 chk({baud_running, irq, line_irq, bus_rdata}, 11'h000);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		br(serial_port_pkg::ADDR_BAUD_LOW);
		chk(rd_val, 8'h04);
		chk(baud_running, 1'b0);
		test_done;
	end
endmodule : test_serial_port_baud_and_regs
